/* hdl/qbg_pkg.sv */
// Purpose: Shared constants for the pin function and phase control block.
// Assumes: Byte-wide register port driven by the serial-bus target logic.
// Notes: Rails 0 to 3 are the switching channels, rail 4 is the standby regulator.
package qbg_pkg;

    // Sizes.
    localparam int NUM_PINS_DEF = 6;
    localparam int NUM_RAILS = 5;
    localparam int NUM_CHAN = 4;
    localparam int NUM_FAULT_SRC = 18;
    localparam int FN_W = 3;
    localparam int ARG_W = 5;
    localparam int DEG_W = 9;

    // Register offsets.
    localparam logic [7:0] OFS_PIN_POLARITY = 8'h00;
    localparam logic [7:0] OFS_OUT_DATA = 8'h01;
    localparam logic [7:0] OFS_IN_STATE = 8'h02;
    localparam logic [7:0] OFS_RAIL_CMD = 8'h03;
    localparam logic [7:0] OFS_RAIL_GOOD = 8'h04;
    localparam logic [7:0] OFS_RAIL_EN = 8'h05;
    localparam logic [7:0] OFS_PHASE_MODE = 8'h06;
    localparam logic [7:0] OFS_PHASE_SEL = 8'h07;
    localparam logic [7:0] OFS_BUS_ADDR = 8'h08;
    localparam logic [7:0] OFS_PIN_FN_BASE = 8'h10;
    localparam logic [7:0] OFS_PIN_ARG_BASE = 8'h18;

    // Pin function codes; unused codes behave as a plain input.
    localparam logic [2:0] FN_INPUT = 3'h0;
    localparam logic [2:0] FN_OUTPUT = 3'h1;
    localparam logic [2:0] FN_CLK_IN = 3'h2;
    localparam logic [2:0] FN_RAIL_EN = 3'h3;
    localparam logic [2:0] FN_PWR_GOOD = 3'h4;
    localparam logic [2:0] FN_FAULT = 3'h5;

    // Fault source indices in the fault source vector.
    localparam int SRC_OVERCUR_FAULT_BASE = 0;
    localparam int SRC_OVERCUR_WARN_BASE = 4;
    localparam int SRC_OVERVOLT_FAULT_BASE = 8;
    localparam int SRC_IN_UNDERVOLT_FAULT_BASE = 12;
    localparam int SRC_IN_UNDERVOLT_WARN_BASE = 14;
    localparam int SRC_OT_FAULT = 16;
    localparam int SRC_OT_WARN = 17;

    // Pins that carry the serial bus while bus mode is active.
    localparam logic [7:0] BUS_PIN_MASK = 8'h30;

    // Phase step sizes in degrees.
    localparam logic [DEG_W-1:0] PHASE_STEP4_DEG = 9'h05a;
    localparam logic [DEG_W-1:0] PHASE_STEP3_DEG = 9'h078;

    // Values after reset.
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [2:0] FN_RST = 3'h0;
    localparam logic [4:0] ARG_RST = 5'h00;
    localparam logic [6:0] BUS_ADDR_RST = 7'h00;
    localparam logic [7:0] PHASE_SEL_RST = 8'h00;

endpackage : qbg_pkg

/* hdl/qbg_sync.sv */
// Purpose: Two-stage synchroniser for a vector of asynchronous levels.
// Assumes: Each bit is an independent level; no bus coherency is implied.
// Notes: The first stage is read by the second stage only.
module qbg_sync
    import qbg_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("qbg_sync: WIDTH must be at least one");
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;

endmodule : qbg_sync

/* hdl/qbg_phase_gen.sv */
// Purpose: Turns the per-channel phase selections into phase offsets in degrees.
// Assumes: Two select bits per channel, channel 0 in the lowest bits.
// Notes: In three-phase mode a select of three wraps to zero degrees.
module qbg_phase_gen
    import qbg_pkg::*;
#(
    parameter int CHAN = NUM_CHAN
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Configuration
    input wire logic three_phase_in,
    input wire logic [2*CHAN-1:0] phase_sel_in,
    // Offsets
    output logic [DEG_W*CHAN-1:0] phase_deg_out
);

    logic [DEG_W*CHAN-1:0] deg_reg;
    logic [DEG_W*CHAN-1:0] deg_next;

    initial begin
        if (CHAN < 1 || CHAN > 4) begin
            $error("qbg_phase_gen: CHAN must be 1 to 4");
        end
    end

    function automatic logic [DEG_W-1:0] step_deg(input logic three, input logic [1:0] sel);
        logic [1:0] s;
        s = (three && sel == 2'h3) ? 2'h0 : sel;
        step_deg = DEG_W'(s) * (three ? PHASE_STEP3_DEG : PHASE_STEP4_DEG);
    endfunction : step_deg

    // Channels may share a step; nothing here forces distinct phases.
    always_comb begin
        deg_next = '0;
        for (int c = 0; c < CHAN; c++) begin
            deg_next[DEG_W*c +: DEG_W] = step_deg(three_phase_in, phase_sel_in[2*c +: 2]);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            deg_reg <= '0;
        end else begin
            deg_reg <= deg_next;
        end
    end

    assign phase_deg_out = deg_reg;

    AST_PHASE_FOUR: assert property (@(posedge clk_in) disable iff (rst_in)
        !three_phase_in ##1 !$past(three_phase_in)
        |-> phase_deg_out[DEG_W-1:0] == DEG_W'($past(phase_sel_in[1:0])) * 9'h05a)
        else $error("Four-phase offset of channel 0 is not a multiple of 90.");
    AST_PHASE_THREE: assert property (@(posedge clk_in) disable iff (rst_in)
        three_phase_in |=> phase_deg_out[DEG_W-1:0] inside {9'h000, 9'h078, 9'h0f0})
        else $error("Three-phase offset of channel 0 is not a multiple of 120.");
    COV_SHARED_PHASE: cover property (@(posedge clk_in) disable iff (rst_in)
        phase_sel_in[1:0] == phase_sel_in[3:2] && phase_sel_in[1:0] != 2'h0);

endmodule : qbg_phase_gen

/* hdl/qbg_gpio_core.sv */
// Purpose: Pin function, polarity, rail enable and phase control of a four-channel controller.
// Assumes: The serial-bus target presents a byte register port; reads answer one cycle later.
// Notes: All pin inputs are synchronised before use; all outputs are registered.
//
// Contract
// - Each channel takes a phase offset in whole quarter periods, or third periods in three-phase mode.
// - Several channels may hold the same phase offset without restriction.
// - A six-bit polarity setting holds one bit per pin, pin zero in bit zero.
// - Polarity inverts received levels of inputs and driven levels of outputs alike.
// - In serial bus mode polarity bits five and four are ignored, as those pins carry the bus.
// - A pin can be configured as the external clock input to the clocking logic.
// - Pin configuration loads from stored configuration bits and later bus writes override it.
// - A rail enable map selects one channel, the standby regulator, or any mix of them.
// - An asserted rail enable pin enables every mapped rail; a deasserted one no longer holds them on, but the host command or another pin can.
// - The host can also enable rails over the bus; each rail is on while the host command or any mapped pin asks for it.
// - A power-good pin asserts only while every mapped rail is within regulation.
// - The per-rail power-good state is readable from a status register.
// - A fault pin signals exactly one selected fault or warning source.
// - The seven-bit bus target address is taken from stored configuration.
// - Every stored configuration and status value is readable over the bus.
module qbg_gpio_core
    import qbg_pkg::*;
#(
    parameter int PIN_COUNT = NUM_PINS_DEF
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Pins
    input wire logic [PIN_COUNT-1:0] gpio_in,
    output logic [PIN_COUNT-1:0] gpio_out,
    output logic [PIN_COUNT-1:0] gpio_oe_out,
    input wire logic host_bus_mode_in,
    // Register port from the serial-bus target
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // Stored configuration load
    input wire logic otp_load_in,
    input wire logic [PIN_COUNT-1:0] otp_pol_in,
    input wire logic [FN_W*PIN_COUNT-1:0] otp_fn_in,
    input wire logic [ARG_W*PIN_COUNT-1:0] otp_arg_in,
    input wire logic [6:0] otp_addr_in,
    // Converter side
    input wire logic [NUM_RAILS-1:0] rail_good_in,
    input wire logic [NUM_FAULT_SRC-1:0] fault_src_in,
    output logic [NUM_RAILS-1:0] rail_en_out,
    output logic ext_clk_out,
    output logic ext_clk_sel_out,
    output logic [6:0] bus_addr_out,
    output logic three_phase_out,
    output logic [DEG_W*NUM_CHAN-1:0] phase_deg_out
);

    initial begin
        if (PIN_COUNT < 6 || PIN_COUNT > 8) begin
            $error("qbg_gpio_core: PIN_COUNT must be 6 to 8");
        end
    end

    // Configuration state.
    logic [PIN_COUNT-1:0] pol_reg, pol_next;
    logic [PIN_COUNT-1:0] out_data_reg, out_data_next;
    logic [NUM_RAILS-1:0] rail_cmd_reg, rail_cmd_next;
    logic three_phase_reg, three_phase_next;
    logic [7:0] phase_sel_reg, phase_sel_next;
    logic [6:0] addr_reg, addr_next;
    logic [FN_W-1:0] fn_reg [PIN_COUNT];
    logic [FN_W-1:0] fn_next [PIN_COUNT];
    logic [ARG_W-1:0] arg_reg [PIN_COUNT];
    logic [ARG_W-1:0] arg_next [PIN_COUNT];

    // Pin state.
    logic [PIN_COUNT-1:0] gpio_out_reg, gpio_out_next;
    logic [PIN_COUNT-1:0] gpio_oe_reg, gpio_oe_next;
    logic [PIN_COUNT-1:0] in_state_reg, in_state_next;
    logic [NUM_RAILS-1:0] rail_en_reg, rail_en_next;
    logic ext_clk_reg, ext_clk_next;
    logic ext_clk_sel_reg, ext_clk_sel_next;
    logic [7:0] rdata_reg, rdata_next;

    // Synchronised pins and derived levels.
    logic [PIN_COUNT:0] sync_q;
    logic [PIN_COUNT-1:0] pin_s;
    logic bus_mode_s;
    logic [PIN_COUNT-1:0] eff_pol;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] bus_held;

    qbg_sync #(
        .WIDTH(PIN_COUNT + 1)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in({host_bus_mode_in, gpio_in}),
        .q_out(sync_q)
    );

    assign pin_s = sync_q[PIN_COUNT-1:0];
    assign bus_mode_s = sync_q[PIN_COUNT];
    assign bus_held = bus_mode_s ? BUS_PIN_MASK[PIN_COUNT-1:0] : '0;
    assign eff_pol = pol_reg & ~bus_held;
    assign level = pin_s ^ eff_pol;

    function automatic logic pin_index_ok(input logic [7:0] addr, input logic [7:0] base);
        pin_index_ok = addr[7:3] == base[7:3] && int'(addr[2:0]) < PIN_COUNT;
    endfunction : pin_index_ok

    function automatic logic fault_pick(input logic [NUM_FAULT_SRC-1:0] src,
                                        input logic [ARG_W-1:0] code);
        fault_pick = (int'(code) < NUM_FAULT_SRC) ? src[code] : 1'b0;
    endfunction : fault_pick

    // Stored bits load first; a bus write in the same cycle lands on top of them.
    always_comb begin
        pol_next = pol_reg;
        out_data_next = out_data_reg;
        rail_cmd_next = rail_cmd_reg;
        three_phase_next = three_phase_reg;
        phase_sel_next = phase_sel_reg;
        addr_next = addr_reg;
        fn_next = fn_reg;
        arg_next = arg_reg;
        if (otp_load_in) begin
            pol_next = otp_pol_in;
            addr_next = otp_addr_in;
            for (int p = 0; p < PIN_COUNT; p++) begin
                fn_next[p] = otp_fn_in[FN_W*p +: FN_W];
                arg_next[p] = otp_arg_in[ARG_W*p +: ARG_W];
            end
        end
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                OFS_PIN_POLARITY: pol_next = reg_wdata_in[PIN_COUNT-1:0];
                OFS_OUT_DATA: out_data_next = reg_wdata_in[PIN_COUNT-1:0];
                OFS_RAIL_CMD: rail_cmd_next = reg_wdata_in[NUM_RAILS-1:0];
                OFS_PHASE_MODE: three_phase_next = reg_wdata_in[0];
                OFS_PHASE_SEL: phase_sel_next = reg_wdata_in;
                default: begin
                    if (pin_index_ok(reg_addr_in, OFS_PIN_FN_BASE)) begin
                        fn_next[reg_addr_in[2:0]] = reg_wdata_in[FN_W-1:0];
                    end else if (pin_index_ok(reg_addr_in, OFS_PIN_ARG_BASE)) begin
                        arg_next[reg_addr_in[2:0]] = reg_wdata_in[ARG_W-1:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pol_reg <= POL_RST[PIN_COUNT-1:0];
            out_data_reg <= '0;
            rail_cmd_reg <= '0;
            three_phase_reg <= 1'b0;
            phase_sel_reg <= PHASE_SEL_RST;
            addr_reg <= BUS_ADDR_RST;
            for (int p = 0; p < PIN_COUNT; p++) begin
                fn_reg[p] <= FN_RST;
                arg_reg[p] <= ARG_RST;
            end
        end else begin
            pol_reg <= pol_next;
            out_data_reg <= out_data_next;
            rail_cmd_reg <= rail_cmd_next;
            three_phase_reg <= three_phase_next;
            phase_sel_reg <= phase_sel_next;
            addr_reg <= addr_next;
            fn_reg <= fn_next;
            arg_reg <= arg_next;
        end
    end

    // Pin roles. Bus pins in bus mode are never driven and never act on rails.
    always_comb begin
        logic drv;
        logic oe;
        drv = 1'b0;
        oe = 1'b0;
        rail_en_next = rail_cmd_reg;
        ext_clk_next = 1'b0;
        ext_clk_sel_next = 1'b0;
        in_state_next = level;
        gpio_out_next = '0;
        gpio_oe_next = '0;
        for (int p = PIN_COUNT - 1; p >= 0; p--) begin
            drv = 1'b0;
            oe = 1'b0;
            if (!bus_held[p]) begin
                unique case (fn_reg[p])
                    FN_OUTPUT: begin
                        drv = out_data_reg[p];
                        oe = 1'b1;
                    end
                    FN_PWR_GOOD: begin
                        drv = (arg_reg[p] != '0) && ((rail_good_in & arg_reg[p]) == arg_reg[p]);
                        oe = 1'b1;
                    end
                    FN_FAULT: begin
                        drv = fault_pick(fault_src_in, arg_reg[p]);
                        oe = 1'b1;
                    end
                    FN_RAIL_EN: begin
                        if (level[p]) begin
                            rail_en_next = rail_en_next | arg_reg[p];
                        end
                    end
                    FN_CLK_IN: begin
                        // The lowest numbered clock pin wins when several are set.
                        ext_clk_next = level[p];
                        ext_clk_sel_next = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
            gpio_oe_next[p] = oe;
            gpio_out_next[p] = oe & (drv ^ eff_pol[p]);
        end
    end

    // Register readback; unmapped offsets read as zero.
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd_in) begin
            rdata_next = 8'h00;
            unique case (reg_addr_in)
                OFS_PIN_POLARITY: rdata_next[PIN_COUNT-1:0] = pol_reg;
                OFS_OUT_DATA: rdata_next[PIN_COUNT-1:0] = out_data_reg;
                OFS_IN_STATE: rdata_next[PIN_COUNT-1:0] = in_state_reg;
                OFS_RAIL_CMD: rdata_next[NUM_RAILS-1:0] = rail_cmd_reg;
                OFS_RAIL_GOOD: rdata_next[NUM_RAILS-1:0] = rail_good_in;
                OFS_RAIL_EN: rdata_next[NUM_RAILS-1:0] = rail_en_reg;
                OFS_PHASE_MODE: rdata_next[0] = three_phase_reg;
                OFS_PHASE_SEL: rdata_next = phase_sel_reg;
                OFS_BUS_ADDR: rdata_next[6:0] = addr_reg;
                default: begin
                    if (pin_index_ok(reg_addr_in, OFS_PIN_FN_BASE)) begin
                        rdata_next[FN_W-1:0] = fn_reg[reg_addr_in[2:0]];
                    end else if (pin_index_ok(reg_addr_in, OFS_PIN_ARG_BASE)) begin
                        rdata_next[ARG_W-1:0] = arg_reg[reg_addr_in[2:0]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gpio_out_reg <= '0;
            gpio_oe_reg <= '0;
            in_state_reg <= '0;
            rail_en_reg <= '0;
            ext_clk_reg <= 1'b0;
            ext_clk_sel_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            gpio_out_reg <= gpio_out_next;
            gpio_oe_reg <= gpio_oe_next;
            in_state_reg <= in_state_next;
            rail_en_reg <= rail_en_next;
            ext_clk_reg <= ext_clk_next;
            ext_clk_sel_reg <= ext_clk_sel_next;
            rdata_reg <= rdata_next;
        end
    end

    qbg_phase_gen #(
        .CHAN(NUM_CHAN)
    ) u_phase (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .three_phase_in(three_phase_reg),
        .phase_sel_in(phase_sel_reg),
        .phase_deg_out(phase_deg_out)
    );

    assign gpio_out = gpio_out_reg;
    assign gpio_oe_out = gpio_oe_reg;
    assign rail_en_out = rail_en_reg;
    assign ext_clk_out = ext_clk_reg;
    assign ext_clk_sel_out = ext_clk_sel_reg;
    assign bus_addr_out = addr_reg;
    assign three_phase_out = three_phase_reg;
    assign reg_rdata_out = rdata_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_RAIL_PIN_ON: assert property (
        fn_reg[0] == FN_RAIL_EN && level[0] |=> (rail_en_out & $past(arg_reg[0])) == $past(arg_reg[0]))
        else $error("Rail enable pin asserted but mapped rails not enabled.");
    AST_RAIL_ALL_OFF: assert property (
        rail_cmd_reg == '0 && (!level[0] || fn_reg[0] != FN_RAIL_EN)
        && fn_reg[1] != FN_RAIL_EN && fn_reg[2] != FN_RAIL_EN && fn_reg[3] != FN_RAIL_EN
        && fn_reg[4] != FN_RAIL_EN && fn_reg[5] != FN_RAIL_EN |=> rail_en_out[0] == 1'b0)
        else $error("Rail enabled with no pin or host request.");
    AST_RAIL_HOST: assert property (
        reg_wr_in && reg_addr_in == OFS_RAIL_CMD |-> ##2 rail_en_out[NUM_RAILS-1:0]
        == ($past(reg_wdata_in[NUM_RAILS-1:0], 2) | rail_en_out))
        else $error("Host rail command did not reach the rail enables.");
    AST_PWR_GOOD: assert property (
        fn_reg[1] == FN_PWR_GOOD && arg_reg[1] != '0 |=> gpio_oe_out[1] && gpio_out[1] ==
        ((($past(rail_good_in) & $past(arg_reg[1])) == $past(arg_reg[1])) ^ $past(pol_reg[1])))
        else $error("Power-good pin disagrees with mapped rail state.");
    AST_FAULT_PIN: assert property (
        fn_reg[2] == FN_FAULT && arg_reg[2] == 5'h10 |=>
        gpio_out[2] == ($past(fault_src_in[SRC_OT_FAULT]) ^ $past(pol_reg[2])))
        else $error("Fault pin does not follow its selected source.");
    AST_INPUT_POL: assert property (
        1'b1 |=> in_state_reg[0] == ($past(pin_s[0]) ^ $past(pol_reg[0])))
        else $error("Input level not inverted by polarity.");
    AST_BUS_PINS: assert property (
        bus_mode_s |=> !gpio_oe_out[4] && !gpio_oe_out[5] && in_state_reg[5:4] == $past(pin_s[5:4]))
        else $error("Bus pins affected by polarity or driven in bus mode.");
    AST_WRITE_WINS: assert property (
        otp_load_in && reg_wr_in && reg_addr_in == OFS_PIN_POLARITY |=>
        pol_reg == $past(reg_wdata_in[PIN_COUNT-1:0]))
        else $error("Bus write did not override the stored polarity.");
    AST_ADDR_LOAD: assert property (
        otp_load_in |=> bus_addr_out == $past(otp_addr_in))
        else $error("Bus address not taken from stored configuration.");
    AST_READ_GOOD: assert property (
        reg_rd_in && reg_addr_in == OFS_RAIL_GOOD |=> reg_rdata_out == {3'h0, $past(rail_good_in)})
        else $error("Rail good status read back wrong.");
    AST_EXT_CLK: assert property (
        fn_reg[4] == FN_CLK_IN && !bus_held[4] && fn_reg[0] != FN_CLK_IN
        && fn_reg[1] != FN_CLK_IN && fn_reg[2] != FN_CLK_IN && fn_reg[3] != FN_CLK_IN
        |=> ext_clk_sel_out && ext_clk_out == $past(level[4]))
        else $error("External clock pin not routed to the clock output.");

    COV_PIN_RAIL: cover property (fn_reg[0] == FN_RAIL_EN && level[0] ##1 rail_en_out[4]);
    COV_PWR_GOOD: cover property (fn_reg[1] == FN_PWR_GOOD ##1 gpio_out[1]);
    COV_BUS_MODE: cover property (bus_mode_s && pol_reg[5:4] != 2'h0);

endmodule : qbg_gpio_core

/* sim/qbg_sys_model.sv */
// Purpose: Behavioural system logic around the pins and the rails.
// Assumes: The system drives a pin only where the device has released it.
// Notes: A rail reports good one cycle after enable unless marked bad.
module qbg_sys_model
    import qbg_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Pins
    input wire logic [5:0] ext_lvl_in,
    input wire logic [5:0] dev_out_in,
    input wire logic [5:0] dev_oe_in,
    output logic [5:0] pin_out,
    // Rails
    input wire logic [4:0] rail_en_in,
    input wire logic [4:0] rail_bad_in,
    output logic [4:0] rail_good_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] good_reg;
    logic [4:0] good_next;
    assign pin_out = (dev_oe_in & dev_out_in) | (~dev_oe_in & ext_lvl_in);
    always_comb begin
        good_next = rail_en_in & ~rail_bad_in;
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            good_reg <= 5'h00;
        end else begin
            good_reg <= good_next;
        end
    end
    assign rail_good_out = good_reg;
endmodule : qbg_sys_model

/* sim/test_qbg_gpio_core.sv */
// Purpose: Self-checking bench for the pin function and phase control block.
// Assumes: Inputs change on falling edges; the system side is qbg_sys_model.
// Notes: Register table loop first, then hand-written pin, phase and load tests.
module test_qbg_gpio_core
    import qbg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic host_bus_mode_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic otp_load_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] reg_rdata_out, rdat;
    logic [5:0] ext = 6'h00;
    logic [5:0] gpio_in, gpio_out, gpio_oe_out;
    logic [5:0] otp_pol_in = 6'h00;
    logic [17:0] otp_fn_in = 18'h00000;
    logic [29:0] otp_arg_in = 30'h00000000;
    logic [6:0] otp_addr_in = 7'h00;
    logic [6:0] bus_addr_out;
    logic [4:0] rail_good_in, rail_en_out;
    logic [4:0] bad = 5'h00;
    logic [17:0] fault_src_in = 18'h00000;
    logic ext_clk_out, ext_clk_sel_out, three_phase_out;
    logic [35:0] phase_deg_out;
    int failures = 0;
    int n_compared = 0;
    localparam logic [23:0] ROWS [8] = '{24'h00ff3f, 24'h03ff1f, 24'h05ff1f, 24'h060101,
                                       24'h07e4e4, 24'h100303, 24'h181f1f, 24'h0faa00};
    always #5 clk_in = ~clk_in;
    qbg_gpio_core qbg_gpio_core_inst (
        .clk_in, .rst_in, .gpio_in, .gpio_out, .gpio_oe_out, .host_bus_mode_in, .reg_wr_in,
        .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .otp_load_in, .otp_pol_in,
        .otp_fn_in, .otp_arg_in, .otp_addr_in, .rail_good_in, .fault_src_in, .rail_en_out,
        .ext_clk_out, .ext_clk_sel_out, .bus_addr_out, .three_phase_out, .phase_deg_out
    );
    qbg_sys_model qbg_sys_model_inst (
        .clk_in, .rst_in, .ext_lvl_in(ext), .dev_out_in(gpio_out), .dev_oe_in(gpio_oe_out),
        .pin_out(gpio_in), .rail_en_in(rail_en_out), .rail_bad_in(bad),
        .rail_good_out(rail_good_in)
    );
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("ERROR at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    // One byte access; read data is taken after the answering edge.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_wr_in = w;
        reg_rd_in = ~w;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        rdat = reg_rdata_out;
    endtask : acc
    task automatic tend(input string s);
        $display("%s done, %0d failures", s, failures);
    endtask : tend
    task automatic stop_test;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        cyc(16);
        rst_in = 1'b0;
        chk(rail_en_out, 5'h00);
        foreach (ROWS[i]) begin
            acc(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
            acc(1'b0, ROWS[i][23:16], 8'h00);
            chk(rdat, ROWS[i][7:0]);
        end
        tend("register table");
        rst_in = 1'b1;
        cyc(2);
        rst_in = 1'b0;
        acc(1'b0, 8'h07, 8'h00);
        chk({three_phase_out, rdat}, 9'h000);
        acc(1'b1, 8'h07, 8'h1b);
        cyc(3);
        chk(phase_deg_out, {9'h000, 9'h05a, 9'h0b4, 9'h10e});
        acc(1'b1, 8'h06, 8'h01);
        cyc(3);
        chk(phase_deg_out, {9'h000, 9'h078, 9'h0f0, 9'h000});
        acc(1'b1, 8'h07, 8'h55);
        cyc(3);
        chk(phase_deg_out, {4{9'h078}});
        tend("phase");
        acc(1'b1, 8'h10, 8'h03);
        acc(1'b1, 8'h18, 8'h11);
        ext[0] = 1'b1;
        cyc(2);
        chk(rail_en_out, 5'h00);
        cyc(2);
        chk(rail_en_out, 5'h11);
        ext[0] = 1'b0;
        cyc(4);
        chk(rail_en_out, 5'h00);
        acc(1'b1, 8'h00, 8'h01);
        cyc(4);
        chk(rail_en_out, 5'h11);
        acc(1'b1, 8'h10, 8'h00);
        tend("rail enable pin");
        acc(1'b1, 8'h11, 8'h04);
        acc(1'b1, 8'h19, 8'h03);
        acc(1'b1, 8'h03, 8'h03);
        cyc(5);
        chk({rail_en_out, gpio_oe_out[1], gpio_out[1]}, 7'h0f);
        bad = 5'h02;
        cyc(3);
        chk(gpio_out[1], 1'b0);
        acc(1'b0, 8'h04, 8'h00);
        chk(rdat, 8'h01);
        bad = 5'h00;
        acc(1'b1, 8'h12, 8'h05);
        acc(1'b1, 8'h1a, 8'h10);
        fault_src_in = 18'h10000;
        cyc(3);
        chk(gpio_out[2], 1'b1);
        fault_src_in = 18'h20000;
        cyc(3);
        chk(gpio_out[2], 1'b0);
        tend("indicators");
        acc(1'b1, 8'h13, 8'h01);
        acc(1'b1, 8'h01, 8'h08);
        acc(1'b1, 8'h00, 8'h08);
        cyc(3);
        chk({gpio_oe_out[3], gpio_out[3]}, 2'b10);
        acc(1'b1, 8'h01, 8'h00);
        cyc(3);
        chk({gpio_oe_out[3], gpio_out[3]}, 2'b11);
        acc(1'b1, 8'h14, 8'h02);
        ext[4] = 1'b1;
        cyc(4);
        chk({ext_clk_sel_out, ext_clk_out}, 2'b11);
        ext[4] = 1'b0;
        cyc(4);
        chk({ext_clk_sel_out, ext_clk_out}, 2'b10);
        host_bus_mode_in = 1'b1;
        acc(1'b1, 8'h00, 8'h30);
        ext[4] = 1'b1;
        cyc(4);
        chk({ext_clk_sel_out, gpio_oe_out[5:4]}, 3'b000);
        acc(1'b0, 8'h02, 8'h00);
        chk(rdat[5:4], 2'b01);
        host_bus_mode_in = 1'b0;
        tend("pin modes");
        @(negedge clk_in);
        otp_load_in = 1'b1;
        otp_addr_in = 7'h5a;
        otp_pol_in = 6'h01;
        cyc(1);
        otp_load_in = 1'b0;
        chk(bus_addr_out, 7'h5a);
        acc(1'b1, 8'h08, 8'h00);
        acc(1'b0, 8'h08, 8'h00);
        chk(rdat, 8'h5a);
        acc(1'b0, 8'h00, 8'h00);
        chk(rdat, 8'h01);
        acc(1'b1, 8'h00, 8'h02);
        acc(1'b0, 8'h00, 8'h00);
        chk(rdat, 8'h02);
        @(negedge clk_in);
        otp_load_in = 1'b1;
        reg_wr_in = 1'b1;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h04;
        @(negedge clk_in);
        otp_load_in = 1'b0;
        reg_wr_in = 1'b0;
        acc(1'b0, 8'h00, 8'h00);
        chk(rdat, 8'h04);
        tend("stored load");
        stop_test;
    end
    initial begin
        #50us;
        failures++;
        stop_test;
    end
endmodule : test_qbg_gpio_core
